// ### pced_pkg.sv
// Shared constants of the pin change edge detector: map, fields, resets.
package pced_pkg;

  // ************************************************************
  // Bus widths and pin counts
  // ************************************************************
  localparam int PCED_ADDR_W = 4;
  localparam int PCED_DATA_W = 8;
  localparam int PCED_PIN_W  = 6;
  localparam int PCED_EVT_W  = 2;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [3:0] PCED_OFS_PA_RISE  = 4'h0;
  localparam logic [3:0] PCED_OFS_PA_FALL  = 4'h1;
  localparam logic [3:0] PCED_OFS_PA_FLAGS = 4'h2;
  localparam logic [3:0] PCED_OFS_PC_RISE  = 4'h3;
  localparam logic [3:0] PCED_OFS_PC_FALL  = 4'h4;
  localparam logic [3:0] PCED_OFS_PC_FLAGS = 4'h5;
  localparam logic [3:0] PCED_OFS_CTRL     = 4'h6;
  localparam logic [3:0] PCED_OFS_STATUS   = 4'h7;
  localparam logic [3:0] PCED_OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0] PCED_OFS_IRQ_MASK = 4'h9;

  // ************************************************************
  // Field positions and masks
  // ************************************************************
  localparam int PCED_CTRL_MASTER_BIT  = 0;
  localparam int PCED_STAT_SUMMARY_BIT = 0;
  localparam int PCED_STAT_DEBUG_BIT   = 1;
  localparam int PCED_EVT_PORTA_BIT    = 0;
  localparam int PCED_EVT_PORTC_BIT    = 1;
  localparam logic [7:0] PCED_DBG_PIN_MASK = 8'h03;

  // ************************************************************
  // Reset values and timing counts
  // ************************************************************
  localparam logic [7:0] PCED_ENABLE_RST = 8'h00;
  localparam logic [7:0] PCED_FLAG_RST   = 8'h00;
  localparam logic [1:0] PCED_WARM_DONE  = 2'h3;

endpackage

// ### pced_edge_det.sv
// Pin synchroniser and per-pin rising and falling edge pulse generator.
`timescale 1ns/1ns
module pced_edge_det
  import pced_pkg::*;
#(
  parameter int PIN_W = PCED_PIN_W
) (
  input  wire logic             clk_i,   // System clock.
  input  wire logic             rst_i,   // Asynchronous reset, high.
  input  wire logic [PIN_W-1:0] pin_i,   // Raw pin levels.
  output logic      [PIN_W-1:0] rise_o,  // One-cycle rising pulses.
  output logic      [PIN_W-1:0] fall_o   // One-cycle falling pulses.
);

  typedef struct packed {
    logic [PIN_W-1:0] meta;
    logic [PIN_W-1:0] sync;
    logic [PIN_W-1:0] prev;
    logic [PIN_W-1:0] rise;
    logic [PIN_W-1:0] fall;
    logic [1:0]       warm;
  } pced_edge_state_t;

  pced_edge_state_t s_r;
  pced_edge_state_t s_nxt;

  // ************************************************************
  // Edge compare
  // ************************************************************
  // Edges are held off until the pipeline holds real samples, so a pin
  // that is high at reset release does not look like a rising edge.
  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = pin_i;
    s_nxt.sync = s_r.meta;
    s_nxt.prev = s_r.sync;
    if (s_r.warm != PCED_WARM_DONE) begin
      s_nxt.warm = s_r.warm + 2'h1;
    end
    if (s_r.warm == PCED_WARM_DONE) begin
      s_nxt.rise = s_r.sync & ~s_r.prev;
      s_nxt.fall = ~s_r.sync & s_r.prev;
    end else begin
      s_nxt.rise = '0;
      s_nxt.fall = '0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rise_o = s_r.rise;
  assign fall_o = s_r.fall;

endmodule // pced_edge_det

// ### pced_irq_ctrl.sv
// Sticky event status with write-one-to-clear, mask and level interrupt.
`timescale 1ns/1ns
module pced_irq_ctrl
  import pced_pkg::*;
#(
  parameter int EVT_W = PCED_EVT_W
) (
  input  wire logic             clk_i,        // System clock.
  input  wire logic             rst_i,        // Asynchronous reset, high.
  input  wire logic [EVT_W-1:0] evt_i,        // Event pulses.
  input  wire logic             master_en_i,  // Gates the interrupt.
  input  wire logic             stat_we_i,    // Write-one-to-clear strobe.
  input  wire logic             mask_we_i,    // Mask write strobe.
  input  wire logic [EVT_W-1:0] wdata_i,      // Write data.
  output logic      [EVT_W-1:0] status_o,     // Sticky status bits.
  output logic      [EVT_W-1:0] mask_o,       // Mask bits.
  output logic                  irq_o         // Level interrupt.
);

  typedef struct packed {
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] mask;
    logic             irq;
  } pced_irq_state_t;

  pced_irq_state_t s_r;
  pced_irq_state_t s_nxt;

  // ************************************************************
  // Status, mask and request
  // ************************************************************
  // A new event in the clearing cycle survives the clear.
  always_comb begin
    s_nxt = s_r;
    if (stat_we_i) begin
      s_nxt.status = s_r.status & ~wdata_i;
    end
    s_nxt.status = s_nxt.status | evt_i;
    if (mask_we_i) begin
      s_nxt.mask = wdata_i;
    end
    s_nxt.irq = master_en_i & (|(s_nxt.status & s_nxt.mask));
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign status_o = s_r.status;
  assign mask_o   = s_r.mask;
  assign irq_o    = s_r.irq;

endmodule // pced_irq_ctrl

// ### pced_top.sv
// Pin change edge detector for two six-pin ports with register port.
//
// How it works
// - Every pin has separate rising and falling detectors, each enabled alone.
// - A set rise enable bit arms the pin's rising detector; clear disarms.
// - A set fall enable bit arms the pin's falling detector; clear disarms.
// - Both enables set make the pin catch edges in either direction.
// - An armed edge sets the pin flag; interrupt only with master enable.
// - Summary request is the OR of all flags, read-only, follows flags.
// - Writing zero clears a flag, one keeps it; only hardware sets flags.
// - An edge during a flag write leaves that flag set regardless.
// - A change event wakes the device when master enable is set.
// - Port A rise enables are bits 5..0; bits 7..6 read zero.
// - Port A fall enables are bits 5..0; bits 7..6 read zero.
// - Port A flag sets on enabled rising or enabled falling edge.
// - All enables and flags reset to zero on every reset.
// - Port C has its own rise and fall enables, present on large variant.
// - With debugger on, port A pins 1 and 0 are unavailable.
// - Detection and flags keep working while master enable is clear.
// - Port C flag sets on enabled rising or enabled falling edge.
`timescale 1ns/1ns
module pced_top
  import pced_pkg::*;
#(
  parameter int PIN_W         = PCED_PIN_W,
  parameter bit PORTC_PRESENT = 1'b1
) (
  input  wire logic                   clk_i,         // System clock.
  input  wire logic                   rst_i,         // Async reset, high.
  input  wire logic [PIN_W-1:0]       port_a_pin_i,  // Port A pins.
  input  wire logic [PIN_W-1:0]       port_c_pin_i,  // Port C pins.
  input  wire logic                   debugger_en_i, // Debugger active.
  input  wire logic [PCED_ADDR_W-1:0] reg_addr_i,    // Register address.
  input  wire logic [PCED_DATA_W-1:0] reg_wdata_i,   // Write data.
  input  wire logic                   reg_we_i,      // Write strobe.
  input  wire logic                   reg_re_i,      // Read strobe.
  output logic      [PCED_DATA_W-1:0] reg_rdata_o,   // Read data.
  output logic                        change_irq_summary_o, // OR of flags.
  output logic                        wake_o,        // Wake request.
  output logic                        irq_o          // Interrupt, level.
);

  // ************************************************************
  // Parameter check
  // ************************************************************
  generate
    if (PIN_W < 1 || PIN_W > PCED_DATA_W) begin : g_bad_pin_w
      $error("PIN_W must lie between 1 and the data width");
    end
  endgenerate

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [PIN_W-1:0]       porta_rise_enable;
    logic [PIN_W-1:0]       porta_fall_enable;
    logic [PIN_W-1:0]       porta_change_flags;
    logic [PIN_W-1:0]       portc_rise_enable;
    logic [PIN_W-1:0]       portc_fall_enable;
    logic [PIN_W-1:0]       portc_change_flags;
    logic                   master_en;
    logic                   summary;
    logic                   wake;
    logic                   dbg_meta;
    logic                   dbg_sync;
    logic [PCED_DATA_W-1:0] rdata;
  } pced_core_state_t;

  pced_core_state_t s_r;
  pced_core_state_t s_nxt;

  logic [PIN_W-1:0]      rise_a;
  logic [PIN_W-1:0]      fall_a;
  logic [PIN_W-1:0]      rise_c;
  logic [PIN_W-1:0]      fall_c;
  logic [PIN_W-1:0]      avail_a;
  logic [PIN_W-1:0]      avail_c;
  logic [PIN_W-1:0]      set_a;
  logic [PIN_W-1:0]      set_c;
  logic [PCED_EVT_W-1:0] evt;
  logic [PCED_EVT_W-1:0] irq_status;
  logic [PCED_EVT_W-1:0] irq_mask;
  logic                  irq_stat_we;
  logic                  irq_mask_we;
  logic                  irq_q;

  // ************************************************************
  // Edge detectors
  // ************************************************************
  pced_edge_det #(
    .PIN_W (PIN_W)
  ) u_edge_a (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (port_a_pin_i),
    .rise_o (rise_a),
    .fall_o (fall_a)
  );

  pced_edge_det #(
    .PIN_W (PIN_W)
  ) u_edge_c (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (port_c_pin_i),
    .rise_o (rise_c),
    .fall_o (fall_c)
  );

  // ************************************************************
  // Pin availability and flag set terms
  // ************************************************************
  // While the debugger owns the two low port A pins their detection,
  // flags and enables read as zero and cannot raise anything.
  always_comb begin
    avail_a = '1;
    if (s_r.dbg_sync) begin
      avail_a = ~PCED_DBG_PIN_MASK[PIN_W-1:0];
    end
    avail_c = PORTC_PRESENT ? '1 : '0;
  end

  // Each pin sets on an enabled rise, an enabled fall, or either.
  assign set_a = ((rise_a & s_r.porta_rise_enable)
               | (fall_a & s_r.porta_fall_enable))
               & avail_a;
  assign set_c = ((rise_c & s_r.portc_rise_enable)
               | (fall_c & s_r.portc_fall_enable))
               & avail_c;

  always_comb begin
    evt                     = '0;
    evt[PCED_EVT_PORTA_BIT] = |set_a;
    evt[PCED_EVT_PORTC_BIT] = |set_c;
  end

  assign irq_stat_we = reg_we_i && (reg_addr_i == PCED_OFS_IRQ_STAT);
  assign irq_mask_we = reg_we_i && (reg_addr_i == PCED_OFS_IRQ_MASK);

  pced_irq_ctrl #(
    .EVT_W (PCED_EVT_W)
  ) u_irq (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .evt_i       (evt),
    .master_en_i (s_r.master_en),
    .stat_we_i   (irq_stat_we),
    .mask_we_i   (irq_mask_we),
    .wdata_i     (reg_wdata_i[PCED_EVT_W-1:0]),
    .status_o    (irq_status),
    .mask_o      (irq_mask),
    .irq_o       (irq_q)
  );

  // ************************************************************
  // Register writes, flags and reads
  // ************************************************************
  always_comb begin
    s_nxt          = s_r;
    s_nxt.dbg_meta = debugger_en_i;
    s_nxt.dbg_sync = s_r.dbg_meta;
    s_nxt.rdata    = '0;
    if (reg_we_i) begin
      unique case (reg_addr_i)
        PCED_OFS_PA_RISE: begin
          s_nxt.porta_rise_enable = reg_wdata_i[PIN_W-1:0];
        end
        PCED_OFS_PA_FALL: begin
          s_nxt.porta_fall_enable = reg_wdata_i[PIN_W-1:0];
        end
        PCED_OFS_PA_FLAGS: begin
          // A one written keeps the flag, a zero clears it.
          s_nxt.porta_change_flags =
            s_r.porta_change_flags & reg_wdata_i[PIN_W-1:0];
        end
        PCED_OFS_PC_RISE: begin
          s_nxt.portc_rise_enable = reg_wdata_i[PIN_W-1:0] & avail_c;
        end
        PCED_OFS_PC_FALL: begin
          s_nxt.portc_fall_enable = reg_wdata_i[PIN_W-1:0] & avail_c;
        end
        PCED_OFS_PC_FLAGS: begin
          s_nxt.portc_change_flags =
            s_r.portc_change_flags & reg_wdata_i[PIN_W-1:0];
        end
        PCED_OFS_CTRL: begin
          s_nxt.master_en = reg_wdata_i[PCED_CTRL_MASTER_BIT];
        end
        default: begin
        end
      endcase
    end
    // Edges seen in the same cycle as a flag write win over it, and
    // detection carries on whatever the master enable holds.
    s_nxt.porta_change_flags =
      (s_nxt.porta_change_flags | set_a) & avail_a;
    s_nxt.portc_change_flags =
      (s_nxt.portc_change_flags | set_c) & avail_c;
    s_nxt.summary = |{s_nxt.porta_change_flags,
                      s_nxt.portc_change_flags};
    s_nxt.wake = s_nxt.master_en & s_nxt.summary;
    if (reg_re_i) begin
      unique case (reg_addr_i)
        PCED_OFS_PA_RISE: begin
          s_nxt.rdata = PCED_DATA_W'(s_r.porta_rise_enable & avail_a);
        end
        PCED_OFS_PA_FALL: begin
          s_nxt.rdata = PCED_DATA_W'(s_r.porta_fall_enable & avail_a);
        end
        PCED_OFS_PA_FLAGS: begin
          s_nxt.rdata = PCED_DATA_W'(s_r.porta_change_flags);
        end
        PCED_OFS_PC_RISE: begin
          s_nxt.rdata = PCED_DATA_W'(s_r.portc_rise_enable);
        end
        PCED_OFS_PC_FALL: begin
          s_nxt.rdata = PCED_DATA_W'(s_r.portc_fall_enable);
        end
        PCED_OFS_PC_FLAGS: begin
          s_nxt.rdata = PCED_DATA_W'(s_r.portc_change_flags);
        end
        PCED_OFS_CTRL: begin
          s_nxt.rdata[PCED_CTRL_MASTER_BIT] = s_r.master_en;
        end
        PCED_OFS_STATUS: begin
          s_nxt.rdata[PCED_STAT_SUMMARY_BIT] = s_r.summary;
          s_nxt.rdata[PCED_STAT_DEBUG_BIT]   = s_r.dbg_sync;
        end
        PCED_OFS_IRQ_STAT: begin
          s_nxt.rdata = PCED_DATA_W'(irq_status);
        end
        PCED_OFS_IRQ_MASK: begin
          s_nxt.rdata = PCED_DATA_W'(irq_mask);
        end
        default: begin
          s_nxt.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata_o          = s_r.rdata;
  assign change_irq_summary_o = s_r.summary;
  assign wake_o               = s_r.wake;
  assign irq_o                = irq_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb_main @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_flag_a_write;
    reg_we_i && (reg_addr_i == PCED_OFS_PA_FLAGS);
  endsequence

  sequence s_no_new_edge_a;
    set_a == '0;
  endsequence

  sequence s_enable_read;
    reg_re_i && (reg_addr_i == PCED_OFS_PA_RISE
                 || reg_addr_i == PCED_OFS_PA_FALL);
  endsequence

  a_edge_sets_flag: assert property (
    (set_a != '0) |=> ((s_r.porta_change_flags & $past(set_a))
                       == $past(set_a)))
    else $error("Armed edge on port A did not set its flag");

  a_portc_edge_flag: assert property (
    (set_c != '0) |=> ((s_r.portc_change_flags & $past(set_c))
                       == $past(set_c)))
    else $error("Armed edge on port C did not set its flag");

  a_flag_only_hw: assert property (
    ##1 ((s_r.porta_change_flags & ~$past(s_r.porta_change_flags)
          & ~$past(set_a)) == '0))
    else $error("Port A flag rose without an armed edge");

  a_zero_write_clear: assert property (
    (s_flag_a_write and s_no_new_edge_a) |=>
      (s_r.porta_change_flags == ($past(s_r.porta_change_flags)
        & $past(reg_wdata_i[PIN_W-1:0]) & $past(avail_a))))
    else $error("Flag write did not clear exactly the zero bits");

  a_summary_tracks: assert property (
    change_irq_summary_o == (|{s_r.porta_change_flags,
                               s_r.portc_change_flags}))
    else $error("Summary request does not match the flags");

  a_irq_master_gate: assert property (
    !s_r.master_en |=> !irq_o)
    else $error("Interrupt raised with master enable clear");

  a_detect_no_master: assert property (
    (!s_r.master_en && set_a != '0) |=> change_irq_summary_o)
    else $error("Detection stopped while master enable clear");

  a_wake_request: assert property (
    (s_nxt.master_en && s_nxt.summary) |=> wake_o)
    else $error("Wake request missing with master enable and flags");

  a_wake_gated: assert property (
    !s_r.master_en |-> !wake_o)
    else $error("Wake request raised with master enable clear");

  a_irq_follows: assert property (
    (s_r.master_en && !reg_we_i && ((irq_status & irq_mask) != '0))
      |=> irq_o)
    else $error("Interrupt missing with master enable and event set");

  a_upper_bits_zero: assert property (
    s_enable_read |=> (reg_rdata_o[PCED_DATA_W-1:PIN_W] == '0))
    else $error("Unimplemented enable bits read nonzero");

  a_debug_pins_off: assert property (
    s_r.dbg_sync [*2] |-> ((s_r.porta_change_flags
                           & PCED_DBG_PIN_MASK[PIN_W-1:0]) == '0))
    else $error("Debugger pins kept a change flag");

  a_portc_flag_hw: assert property (
    ##1 ((s_r.portc_change_flags & ~$past(s_r.portc_change_flags)
          & ~$past(set_c)) == '0))
    else $error("Port C flag rose without an armed edge");

  a_rise_pulse_once: assert property (
    (rise_a != '0) |=> ((rise_a & $past(rise_a)) == '0))
    else $error("Rising edge pulse lasted more than one cycle");

endmodule // pced_top

// ### pced_pin_model.sv
// Far-side model of the two external input ports driving the detector.
`timescale 1ns/1ns
module pced_pin_model #(
  parameter int PIN_W = 6
) (
  input  wire logic             clk_i,         // System clock.
  input  wire logic             rst_i,         // Async reset, high.
  input  wire logic [PIN_W-1:0] lvl_a_i,       // Requested port A levels.
  input  wire logic [PIN_W-1:0] lvl_c_i,       // Requested port C levels.
  output logic      [PIN_W-1:0] port_a_pin_o,  // Port A pin levels.
  output logic      [PIN_W-1:0] port_c_pin_o   // Port C pin levels.
);
  // Levels change only just after an edge and hold at least one cycle.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_a_pin_o <= '0;
      port_c_pin_o <= '0;
    end else begin
      port_a_pin_o <= lvl_a_i;
      port_c_pin_o <= lvl_c_i;
    end
  end
endmodule // pced_pin_model

// ### pin_change_edge_detector_bench.sv
// Self-checking testbench of the pin change edge detector.
`timescale 1ns/1ns
module pin_change_edge_detector_bench;
  import pced_pkg::*;
  logic       clk_i, rst_i, dbg, we, re, summ, wake, irq;
  logic [5:0] lvl_a, lvl_c, pa, pc;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  int         n_mismatch, check_count;
  // ************************************************************
  // Clock, reset, design and pins
  // ************************************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  pced_pin_model u_pins (.clk_i(clk_i), .rst_i(rst_i), .lvl_a_i(lvl_a),
    .lvl_c_i(lvl_c), .port_a_pin_o(pa), .port_c_pin_o(pc));
  pced_top uut (.clk_i(clk_i), .rst_i(rst_i), .port_a_pin_i(pa),
    .port_c_pin_i(pc), .debugger_en_i(dbg), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
    .change_irq_summary_o(summ), .wake_o(wake), .irq_o(irq));
  // ************************************************************
  // Access and compare tasks
  // ************************************************************
  task automatic chk8(string name, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk1(string name, logic exp, logic got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk_i);
    we    <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk_i);
    re   <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rdchk(string name, logic [3:0] a, logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk8(name, exp, d);
  endtask
  // Clears only the flags just seen, so that newer edges survive.
  task automatic clr(logic [3:0] a);
    logic [7:0] d;
    rd(a, d);
    wr(a, ~d);
  endtask
  task automatic pins(logic [5:0] a, logic [5:0] c);
    @(posedge clk_i);
    lvl_a <= a;
    lvl_c <= c;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic outs(logic s, logic w, logic i);
    repeat (2) @(posedge clk_i);
    #1;
    chk1("summary", s, summ);
    chk1("wake", w, wake);
    chk1("irq", i, irq);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ************************************************************
  // Watchdog
  // ************************************************************
  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    $display("ERROR watchdog expected done seen timeout");
    test_done;
  end
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    logic [3:0] en_ofs[4];
    en_ofs = '{PCED_OFS_PA_RISE, PCED_OFS_PA_FALL, PCED_OFS_PC_RISE,
               PCED_OFS_PC_FALL};
    rst_i = 1'b1;
    dbg = 1'b0; we = 1'b0; re = 1'b0;
    lvl_a = 6'h00; lvl_c = 6'h00; addr = 4'h0; wdata = 8'h00;
    n_mismatch = 0;
    check_count = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i <= 10; i++)
      rdchk("reset value", 4'(i), 8'h00);
    $display("test reset values done");
    foreach (en_ofs[k]) begin
      wr(en_ofs[k], 8'hFF);
      rdchk("enable width", en_ofs[k], 8'h3F);
      wr(en_ofs[k], 8'h00);
    end
    $display("test enable widths done");
    wr(PCED_OFS_PA_RISE, 8'h05);
    wr(PCED_OFS_PA_FALL, 8'h06);
    wr(PCED_OFS_IRQ_MASK, 8'h01);
    pins(6'h3F, 6'h00);
    rdchk("port a rise flags", PCED_OFS_PA_FLAGS, 8'h05);
    outs(1'b1, 1'b0, 1'b0);
    rdchk("event status", PCED_OFS_IRQ_STAT, 8'h01);
    clr(PCED_OFS_PA_FLAGS);
    rdchk("flags cleared", PCED_OFS_PA_FLAGS, 8'h00);
    outs(1'b0, 1'b0, 1'b0);
    pins(6'h00, 6'h00);
    rdchk("port a fall flags", PCED_OFS_PA_FLAGS, 8'h06);
    wr(PCED_OFS_PA_FLAGS, 8'hFF);
    rdchk("ones keep flags", PCED_OFS_PA_FLAGS, 8'h06);
    $display("test port a edges done");
    wr(PCED_OFS_CTRL, 8'h01);
    outs(1'b1, 1'b1, 1'b1);
    wr(PCED_OFS_IRQ_MASK, 8'h00);
    outs(1'b1, 1'b1, 1'b0);
    wr(PCED_OFS_IRQ_MASK, 8'h01);
    wr(PCED_OFS_IRQ_STAT, 8'h01);
    rdchk("event cleared", PCED_OFS_IRQ_STAT, 8'h00);
    outs(1'b1, 1'b1, 1'b0);
    clr(PCED_OFS_PA_FLAGS);
    outs(1'b0, 1'b0, 1'b0);
    $display("test master enable done");
    wr(PCED_OFS_PC_RISE, 8'h20);
    wr(PCED_OFS_PC_FALL, 8'h01);
    pins(6'h00, 6'h21);
    rdchk("port c rise flags", PCED_OFS_PC_FLAGS, 8'h20);
    pins(6'h00, 6'h00);
    rdchk("port c both flags", PCED_OFS_PC_FLAGS, 8'h21);
    rdchk("port c event", PCED_OFS_IRQ_STAT, 8'h02);
    clr(PCED_OFS_PC_FLAGS);
    rdchk("port c cleared", PCED_OFS_PC_FLAGS, 8'h00);
    $display("test port c edges done");
    // The clearing write lands on the very edge that sets the flag:
    // pin model, two sync stages and the pulse register take four edges.
    @(posedge clk_i);
    lvl_a <= 6'h01;
    repeat (3) @(posedge clk_i);
    wr(PCED_OFS_PA_FLAGS, 8'h00);
    repeat (4) @(posedge clk_i);
    rdchk("set beats clear", PCED_OFS_PA_FLAGS, 8'h01);
    clr(PCED_OFS_PA_FLAGS);
    $display("test set during clear done");
    dbg <= 1'b1;
    repeat (3) @(posedge clk_i);
    wr(PCED_OFS_PA_RISE, 8'h3F);
    rdchk("debug enables", PCED_OFS_PA_RISE, 8'h3C);
    pins(6'h07, 6'h00);
    rdchk("debug flags", PCED_OFS_PA_FLAGS, 8'h04);
    rdchk("status", PCED_OFS_STATUS, 8'h03);
    dbg <= 1'b0;
    $display("test debugger done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk("rerun rise", PCED_OFS_PA_RISE, 8'h00);
    rdchk("rerun flags", PCED_OFS_PA_FLAGS, 8'h00);
    rdchk("rerun ctrl", PCED_OFS_CTRL, 8'h00);
    outs(1'b0, 1'b0, 1'b0);
    $display("test second reset done");
    test_done;
  end
endmodule // pin_change_edge_detector_bench
